//--- design/ecw_regs.sv
`timescale 1ns/1ps

// Summary of operation
// - Status bits 0-3 show aggregated INTA..INTD
// - Window address bits 7:2 hold dword index
// - Window address bits 11:8 hold extended index
// - Window data read returns selected register
// - Window data write updates selected register
// - Window accesses reuse the original byte enables
// - Window aimed at itself reads zero, drops writes
// - Serial path window data reads zero, writes nothing
// - Channel header reads identifier 0x2, version 0x1
// - Channel header next link reads zero
// - Extra and low-priority channel counts read zero
// - Time base field reads zero
// - Arbitration entry size reads 0x1 (2-bit)
module ecw_regs
	import ecw_pkg::*;
(
	// Clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rst_i,
	// Aggregated legacy interrupt lines, same clock
	input  wire logic [3:0]        intx_i,
	// Configuration request and answer
	input  wire ecw_req_t          req_i,
	output ecw_rsp_t               rsp_o,
	// Window pointer for observation
	output logic      [9:0]        win_idx_o
);

	// Registered state and its next values
	logic [3:0]  intx_r;
	logic [9:0]  win_idx_r;
	logic [9:0]  win_idx_nxt;
	ecw_rsp_t    rsp_r;
	ecw_rsp_t    rsp_nxt;

	// Request decode
	logic [9:0]  dir_idx;
	logic        via_window;
	logic        self_window;
	logic        serial_window;
	logic        blocked;
	logic [9:0]  eff_idx;
	logic        do_read;
	logic        do_write;
	logic        store_we;
	logic        win_adr_we;

	// Register images as they read back
	logic [31:0] int_sts_now;
	logic [31:0] win_adr_now;
	logic [31:0] win_adr_merged;
	logic [31:0] vc_hdr_now;
	logic [31:0] pvc_cap_now;
	logic [31:0] store_rdata;
	logic [31:0] rd_value;

	// Byte-lane merge used for the window pointer update only
	function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
			input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < ECW_BE_W; b++) begin
			if (be[b]) begin
				res[ECW_BYTE_W*b +: ECW_BYTE_W] = new_v[ECW_BYTE_W*b +: ECW_BYTE_W];
			end
		end
		return res;
	endfunction

	// Indices served here rather than by the store
	function automatic logic is_local(input logic [9:0] idx);
		return (idx == ECW_IDX_INT_STS) || (idx == ECW_IDX_WIN_ADR) || (idx == ECW_IDX_WIN_DAT) ||
			(idx == ECW_IDX_VC_HDR) || (idx == ECW_IDX_PVC_CAP);
	endfunction

	// Status image: line state in the low bits, the rest reserved
	function automatic logic [31:0] int_sts_image(input logic [3:0] lines);
		logic [31:0] w;
		w = ECW_ZERO;
		w[ECW_INTX_W-1:0] = lines;
		return w;
	endfunction

	// Both index fields sit side by side, so the pointer maps as one slice
	function automatic logic [31:0] win_adr_word(input logic [9:0] idx);
		logic [31:0] w;
		w = ECW_ZERO;
		w[ECW_EXT_IDX_MSB:ECW_DW_IDX_LSB] = idx;
		return w;
	endfunction

	function automatic logic [31:0] vc_hdr_word();
		logic [31:0] w;
		w = ECW_ZERO;
		w[ECW_CAP_ID_MSB:ECW_CAP_ID_LSB]   = ECW_CAP_ID;
		w[ECW_CAP_VER_MSB:ECW_CAP_VER_LSB] = ECW_CAP_VER;
		w[ECW_NEXT_MSB:ECW_NEXT_LSB]       = ECW_NEXT_LINK;
		return w;
	endfunction

	function automatic logic [31:0] pvc_cap_word();
		logic [31:0] w;
		w = ECW_ZERO;
		w[ECW_XCNT_MSB:ECW_XCNT_LSB]   = ECW_EXTRA_CNT;
		w[ECW_LPCNT_MSB:ECW_LPCNT_LSB] = ECW_LOWPRI_CNT;
		w[ECW_TBASE_MSB:ECW_TBASE_LSB] = ECW_WRR_TBASE;
		w[ECW_ARB_MSB:ECW_ARB_LSB]     = ECW_ARB_ENT;
		return w;
	endfunction

	// Register images
	assign int_sts_now   = int_sts_image(intx_r);
	assign win_adr_now   = win_adr_word(win_idx_r);
	assign vc_hdr_now    = vc_hdr_word();
	assign pvc_cap_now   = pvc_cap_word();

	// Request decode
	assign dir_idx       = req_i.addr[ECW_BADDR_W-1:ECW_IDX_LSB];
	assign via_window    = (dir_idx == ECW_IDX_WIN_DAT);
	assign eff_idx       = via_window ? win_idx_r : dir_idx;
	// A window aimed at itself would recurse; it falls dead instead
	assign self_window   = via_window && (win_idx_r == ECW_IDX_WIN_DAT);
	// The serial slave path may not reach through the window at all
	assign serial_window = via_window && req_i.smbus;
	assign blocked       = self_window || serial_window;
	assign do_read       = req_i.valid && !req_i.write;
	assign do_write      = req_i.valid && req_i.write && !blocked;
	assign store_we      = do_write && !is_local(eff_idx);
	assign win_adr_we    = do_write && (eff_idx == ECW_IDX_WIN_ADR);

	ecw_cfg_store #(
		.IDX_W   (ECW_IDX_W)
	) u_store (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.idx_i     (eff_idx),
		.we_i      (store_we),
		.be_i      (req_i.be),
		.wdata_i   (req_i.wdata),
		.rdata_o   (store_rdata)
	);

	// Read multiplexer, shared by direct and window reads
	always_comb begin
		rd_value = ECW_ZERO;
		if (!blocked) begin
			case (eff_idx)
				ECW_IDX_INT_STS: rd_value = int_sts_now;
				ECW_IDX_WIN_ADR: rd_value = win_adr_now;
				ECW_IDX_WIN_DAT: rd_value = ECW_ZERO;
				ECW_IDX_VC_HDR:  rd_value = vc_hdr_now;
				ECW_IDX_PVC_CAP: rd_value = pvc_cap_now;
				default:         rd_value = store_rdata;
			endcase
		end
	end

	// Interrupt line state, sampled every cycle
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			intx_r <= ECW_INTX_RST;
		end else begin
			intx_r <= intx_i;
		end
	end

	// Byte enables of the original access shape the pointer update
	assign win_adr_merged = merge_be(win_adr_now, req_i.wdata, req_i.be);

	// Window pointer; a window write aimed at it acts as a direct one
	always_comb begin
		win_idx_nxt = win_idx_r;
		if (win_adr_we) begin
			win_idx_nxt = win_adr_merged[ECW_EXT_IDX_MSB:ECW_DW_IDX_LSB];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			win_idx_r <= ECW_WIN_IDX_RST;
		end else begin
			win_idx_r <= win_idx_nxt;
		end
	end

	// Writes are answered too, with zero data
	always_comb begin
		rsp_nxt       = ECW_RSP_RST;
		rsp_nxt.valid = req_i.valid;
		if (do_read) begin
			rsp_nxt.rdata = rd_value;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rsp_r <= ECW_RSP_RST;
		end else begin
			rsp_r <= rsp_nxt;
		end
	end

	assign rsp_o     = rsp_r;
	assign win_idx_o = win_idx_r;

endmodule // ecw_regs

//--- design/ecw_pkg.sv
package ecw_pkg;

	// Geometry of the configuration space
	localparam int          ECW_DATA_W      = 32;
	localparam int          ECW_BE_W        = 4;
	localparam int          ECW_BADDR_W     = 12;
	localparam int          ECW_IDX_W       = 10;
	localparam int          ECW_IDX_LSB     = 2;
	localparam int          ECW_INTX_W      = 4;

	// Byte addresses of the registers held here
	localparam logic [11:0] ECW_OFF_INT_STS = 12'h0F4;
	localparam logic [11:0] ECW_OFF_WIN_ADR = 12'h0F8;
	localparam logic [11:0] ECW_OFF_WIN_DAT = 12'h0FC;
	localparam logic [11:0] ECW_OFF_VC_HDR  = 12'h100;
	localparam logic [11:0] ECW_OFF_PVC_CAP = 12'h104;

	// Dword indices derived from the byte addresses
	localparam logic [9:0]  ECW_IDX_INT_STS = ECW_OFF_INT_STS[11:2];
	localparam logic [9:0]  ECW_IDX_WIN_ADR = ECW_OFF_WIN_ADR[11:2];
	localparam logic [9:0]  ECW_IDX_WIN_DAT = ECW_OFF_WIN_DAT[11:2];
	localparam logic [9:0]  ECW_IDX_VC_HDR  = ECW_OFF_VC_HDR[11:2];
	localparam logic [9:0]  ECW_IDX_PVC_CAP = ECW_OFF_PVC_CAP[11:2];

	// Window address field layout
	localparam int          ECW_DW_IDX_LSB  = 2;
	localparam int          ECW_DW_IDX_MSB  = 7;
	localparam int          ECW_EXT_IDX_LSB = 8;
	localparam int          ECW_EXT_IDX_MSB = 11;
	localparam logic [9:0]  ECW_WIN_IDX_RST = 10'h000;

	// Virtual channel header fields
	localparam logic [15:0] ECW_CAP_ID      = 16'h0002;
	localparam logic [3:0]  ECW_CAP_VER     = 4'h1;
	localparam logic [11:0] ECW_NEXT_LINK   = 12'h000;

	// Port channel capability one fields
	localparam logic [2:0]  ECW_EXTRA_CNT   = 3'h0;
	localparam logic [2:0]  ECW_LOWPRI_CNT  = 3'h0;
	localparam logic [1:0]  ECW_WRR_TBASE   = 2'h0;
	localparam logic [1:0]  ECW_ARB_ENT_1B  = 2'h0;
	localparam logic [1:0]  ECW_ARB_ENT_2B  = 2'h1;
	localparam logic [1:0]  ECW_ARB_ENT_4B  = 2'h2;
	localparam logic [1:0]  ECW_ARB_ENT_8B  = 2'h3;
	localparam logic [1:0]  ECW_ARB_ENT     = ECW_ARB_ENT_2B;

	// Channel header field positions
	localparam int          ECW_CAP_ID_LSB  = 0;
	localparam int          ECW_CAP_ID_MSB  = 15;
	localparam int          ECW_CAP_VER_LSB = 16;
	localparam int          ECW_CAP_VER_MSB = 19;
	localparam int          ECW_NEXT_LSB    = 20;
	localparam int          ECW_NEXT_MSB    = 31;

	// Port channel capability one field positions
	localparam int          ECW_XCNT_LSB    = 0;
	localparam int          ECW_XCNT_MSB    = 2;
	localparam int          ECW_LPCNT_LSB   = 4;
	localparam int          ECW_LPCNT_MSB   = 6;
	localparam int          ECW_TBASE_LSB   = 8;
	localparam int          ECW_TBASE_MSB   = 9;
	localparam int          ECW_ARB_LSB     = 10;
	localparam int          ECW_ARB_MSB     = 11;

	// Byte lane width
	localparam int          ECW_BYTE_W      = 8;

	localparam logic [31:0] ECW_ZERO        = 32'h0000_0000;
	localparam logic [3:0]  ECW_INTX_RST    = 4'h0;

	// Configuration request from the upstream or the serial slave path
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        smbus;
		logic [11:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} ecw_req_t;

	// Answer, one cycle after the request
	typedef struct packed {
		logic        valid;
		logic [31:0] rdata;
	} ecw_rsp_t;

	localparam ecw_rsp_t    ECW_RSP_RST     = '{valid: 1'b0, rdata: 32'h0000_0000};

endpackage

//--- design/ecw_cfg_store.sv
`timescale 1ns/1ps

// Backing store for the rest of the configuration space
module ecw_cfg_store
	import ecw_pkg::*;
#(
	parameter int IDX_W = ECW_IDX_W
) (
	// Clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rst_i,
	// Access port
	input  wire logic [IDX_W-1:0]  idx_i,
	input  wire logic              we_i,
	input  wire logic [3:0]        be_i,
	input  wire logic [31:0]       wdata_i,
	output logic      [31:0]       rdata_o
);

	logic [31:0] mem_r [0:(1<<IDX_W)-1];

	// Asynchronous read keeps the answer one cycle after the request
	assign rdata_o = mem_r[idx_i];

	// Storage carries no reset so it maps onto plain memory
	always_ff @(posedge sys_clk_i) begin
		if (we_i && !rst_i) begin
			for (int b = 0; b < ECW_BE_W; b++) begin
				if (be_i[b]) begin
					mem_r[idx_i][ECW_BYTE_W*b +: ECW_BYTE_W] <= wdata_i[ECW_BYTE_W*b +: ECW_BYTE_W];
				end
			end
		end
	end

endmodule // ecw_cfg_store

//--- dv/ecw_regs_chk.sv
`timescale 1ns/1ps
module ecw_regs_chk
	import ecw_pkg::*;
(
	input wire logic       sys_clk_i,
	input wire logic       rst_i,
	input wire logic [3:0] intx_i,
	input wire ecw_req_t   req_i,
	input wire ecw_rsp_t   rsp_o,
	input wire logic [9:0] win_idx_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	wire       rd_v = req_i.valid && !req_i.write;
	wire       wr_v = req_i.valid && req_i.write;
	wire [9:0] ix   = req_i.addr[11:2];
	chk_answer_next: assert property (req_i.valid |=> rsp_o.valid)
		else $error("answer missing");
	chk_hdr_const: assert property (rd_v && ix == ECW_IDX_VC_HDR |=> rsp_o.rdata == 32'h0001_0002)
		else $error("channel header wrong");
	chk_pvc_const: assert property (rd_v && ix == ECW_IDX_PVC_CAP |=> rsp_o.rdata == 32'h0000_0400)
		else $error("port capability wrong");
	chk_int_status: assert property (rd_v && ix == ECW_IDX_INT_STS && $stable(intx_i)
		|=> rsp_o.rdata == {28'h0, $past(intx_i)})
		else $error("status wrong");
	chk_smb_window: assert property (rd_v && req_i.smbus && ix == ECW_IDX_WIN_DAT |=> rsp_o.rdata == 32'h0)
		else $error("serial window read not zero");
	chk_self_window: assert property (rd_v && ix == ECW_IDX_WIN_DAT && win_idx_o == ECW_IDX_WIN_DAT
		|=> rsp_o.rdata == 32'h0)
		else $error("self window read not zero");
	chk_ptr_update: assert property (wr_v && ix == ECW_IDX_WIN_ADR && req_i.be == 4'hF
		|=> win_idx_o == $past(req_i.wdata[11:2]))
		else $error("pointer not loaded");
	chk_ptr_hold: assert property (!wr_v |=> $stable(win_idx_o))
		else $error("pointer moved");
	cover property (rd_v && ix == ECW_IDX_WIN_DAT);
	cover property (wr_v && ix == ECW_IDX_WIN_DAT);
	cover property (rd_v && req_i.smbus);
	cover property (wr_v && ix == ECW_IDX_WIN_DAT && win_idx_o == ECW_IDX_WIN_ADR);
endmodule // ecw_regs_chk

bind ecw_regs ecw_regs_chk u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .intx_i(intx_i), .req_i(req_i),
	.rsp_o(rsp_o), .win_idx_o(win_idx_o));

//--- dv/ecw_rc_model.sv
`timescale 1ns/1ps
module ecw_rc_model
	import ecw_pkg::*;
(
	input  wire logic     sys_clk_i,
	output ecw_req_t      req_o,
	input  wire ecw_rsp_t rsp_i
);
	initial req_o = '0;
	// Idle fields inverted so a stale value never looks valid
	task automatic xfer(input logic w, input logic s, input logic [11:0] a, input logic [3:0] be,
		input logic [31:0] d, output logic [31:0] q);
		@(negedge sys_clk_i);
		req_o <= {1'h1, w, s, a, be, d};
		@(negedge sys_clk_i);
		q = (rsp_i.valid === 1'h1) ? rsp_i.rdata : 32'hXXXX_XXXX;
		req_o <= {1'h0, ~w, ~s, ~a, ~be, ~d};
	endtask
endmodule // ecw_rc_model

//--- dv/test_ecw_regs.sv
`timescale 1ns/1ps
module test_ecw_regs;
	import ecw_pkg::*;
	logic        sys_clk_i = 1'h0;
	logic        rst_i     = 1'h1;
	logic [3:0]  intx_i    = 4'h0;
	ecw_req_t    req;
	ecw_rsp_t    rsp;
	logic [9:0]  win;
	logic [31:0] q;
	int          n_errors  = 0;
	int          compares  = 0;
	int          cyc       = 0;
	always #25 sys_clk_i = ~sys_clk_i;
	ecw_regs dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .intx_i(intx_i), .req_i(req), .rsp_o(rsp), .win_idx_o(win));
	ecw_rc_model rc (.sys_clk_i(sys_clk_i), .req_o(req), .rsp_i(rsp));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic s, input logic [11:0] a, input logic [31:0] exp);
		rc.xfer(1'h0, s, a, 4'hF, 32'h0, q);
		chk(q, exp);
	endtask
	// Writes answer with zero data
	task automatic wr(input logic s, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
		rc.xfer(1'h1, s, a, be, d, q);
		chk(q, 32'h0);
	endtask
	task automatic wrap_up();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (10) @(negedge sys_clk_i);
		rst_i = 1'h0;
		rd(1'h0, 12'h100, 32'h0001_0002);
		rd(1'h0, 12'h104, 32'h0000_0400);
		wr(1'h0, 12'h100, 4'hF, 32'hFFFF_FFFF);
		rd(1'h0, 12'h100, 32'h0001_0002);
		for (int i = 0; i < 5; i++) begin
			intx_i = (i == 4) ? 4'hF : 4'h1 << i;
			rd(1'h0, 12'h0F4, {28'h0, intx_i});
		end
		$display("constants and status done");
		wr(1'h0, 12'h0F8, 4'hF, 32'hFFFF_F510);
		rd(1'h0, 12'h0F8, 32'h0000_0510);
		chk({22'h0, win}, 32'h0000_0144);
		wr(1'h0, 12'h510, 4'hF, 32'h1234_5678);
		rd(1'h0, 12'h0FC, 32'h1234_5678);
		wr(1'h0, 12'h0FC, 4'h3, 32'hAAAA_BBBB);
		rd(1'h0, 12'h510, 32'h1234_BBBB);
		$display("window done");
		rd(1'h1, 12'h0FC, 32'h0);
		wr(1'h1, 12'h0FC, 4'hF, 32'h0);
		rd(1'h0, 12'h510, 32'h1234_BBBB);
		rd(1'h1, 12'h0F8, 32'h0000_0510);
		wr(1'h0, 12'h0F8, 4'hF, 32'h0000_00FC);
		rd(1'h0, 12'h0FC, 32'h0);
		wr(1'h0, 12'h0FC, 4'hF, 32'h0000_0104);
		rd(1'h0, 12'h0F8, 32'h0000_00FC);
		wr(1'h0, 12'h0F8, 4'hF, 32'h0000_00F8);
		wr(1'h0, 12'h0FC, 4'h1, 32'hFFFF_FF10);
		chk({22'h0, win}, 32'h0000_0004);
		rd(1'h0, 12'h0F8, 32'h0000_0010);
		$display("refusals done");
		wrap_up();
	end
endmodule // test_ecw_regs
